// >>> design/flash_array_engine.sv
// Flash array, page buffer and timed program/erase engine
`timescale 1ns/1ps
`include "flash_prog_defines.svh"

module flash_array_engine #(
  parameter int unsigned AW           = 17,
  parameter int unsigned PW           = `PAGE_WIDTH,
  parameter int unsigned PGM_CYCLES   = 32'(`WRITE_CYCLES),
  parameter int unsigned ERASE_CYCLES = 32'(`ERASE_CYCLES)
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          load_en,
  input  wire logic [PW-1:0] load_idx,
  input  wire logic [7:0]    load_data,
  input  wire logic          start_pgm,
  input  wire logic          start_erase,
  input  wire logic [AW-1:0] page_base,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data,
  output logic               busy,
  output logic               done,
  output logic               pgm_fail
);

  localparam int unsigned PAGE = 1 << PW;

  logic [7:0]    mem [0:(1<<AW)-1];
  logic [7:0]    page_buf [0:PAGE-1];
  logic          busy_reg;
  logic          erase_reg;
  logic          sweeping_reg;
  logic          fail_reg;
  logic          done_reg;
  logic [AW-1:0] sweep_reg;
  logic [31:0]   timer_reg;
  logic [7:0]    rd_data_reg;

  // Sweep address, merged data and failure check
  wire [AW-1:0] wr_addr    = erase_reg ? sweep_reg : {page_base[AW-1:PW], sweep_reg[PW-1:0]};
  wire [7:0]    cur_byte   = mem[wr_addr];
  wire [7:0]    src_byte   = page_buf[sweep_reg[PW-1:0]];
  wire [7:0]    wr_data    = erase_reg ? `ERASED_BYTE : (cur_byte & src_byte);
  wire          bad_bits   = !erase_reg && ((src_byte & ~cur_byte) != 8'h00);
  wire          sweep_last = erase_reg ? (&sweep_reg) : (&sweep_reg[PW-1:0]);
  wire          start      = !busy_reg && (start_pgm || start_erase);

  // Array and page buffer storage, no reset
  always_ff @(posedge sys_clk) begin
    if (load_en) begin
      page_buf[load_idx] <= load_data;
    end
    if (busy_reg && sweeping_reg) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  // Operation sequencing: sweep then wait out the minimum time
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg     <= 1'b0;
      erase_reg    <= 1'b0;
      sweeping_reg <= 1'b0;
      fail_reg     <= 1'b0;
      done_reg     <= 1'b0;
      sweep_reg    <= '0;
      timer_reg    <= 32'h0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        busy_reg     <= 1'b1;
        erase_reg    <= start_erase;
        sweeping_reg <= 1'b1;
        fail_reg     <= 1'b0;
        sweep_reg    <= '0;
        timer_reg    <= start_erase ? ERASE_CYCLES : PGM_CYCLES;
      end else if (busy_reg) begin
        if (timer_reg != 32'h0) begin
          timer_reg <= timer_reg - 32'h1;
        end
        if (sweeping_reg) begin
          sweep_reg <= sweep_reg + 1'b1;
          if (sweep_last) begin
            sweeping_reg <= 1'b0;
          end
          if (bad_bits) begin
            fail_reg <= 1'b1;
          end
        end else if (timer_reg == 32'h0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign rd_data  = rd_data_reg;
  assign busy     = busy_reg;
  assign done     = done_reg;
  assign pgm_fail = fail_reg;

endmodule

// >>> design/flash_prog_defines.svh
// Constants shared by the programmer command port and its flash engine
`ifndef FLASH_PROG_DEFINES_SVH
`define FLASH_PROG_DEFINES_SVH

// Command codes written in the first cycle
`define CMD_MEM_READ      8'h00
`define CMD_AUTO_PGM      8'h40
`define CMD_AUTO_ERASE    8'h20
`define CMD_STATUS_READ   8'h71

// Program burst geometry
`define PAGE_WIDTH        7
`define PAGE_LAST         7'h7f
`define PAGE_ALIGN_LO     8'h00
`define PAGE_ALIGN_HI     8'h80
`define ERASED_BYTE       8'hff

// Status polling bytes
`define POLL_BUSY         8'h00
`define POLL_ABNORMAL     8'h80
`define POLL_NORMAL       8'hc0

// Status return byte fields
`define ST_ABNORMAL_BIT   7
`define ST_CMD_ERR_BIT    6
`define ST_PGM_ERR_BIT    5
`define ST_ERASE_ERR_BIT  4
`define ST_COUNT_ERR_BIT  1
`define ST_ADDR_ERR_BIT   0
`define STATUS_RESET      8'h00

// Timing
`define CLK_HZ            64'd50000000
`define WRITE_TIME_MS     64'd1
`define ERASE_TIME_MS     64'd100
`define WRITE_CYCLES      ((`WRITE_TIME_MS * `CLK_HZ + 64'd999) / 64'd1000)
`define ERASE_CYCLES      ((`ERASE_TIME_MS * `CLK_HZ + 64'd999) / 64'd1000)

`endif

// >>> design/flash_prog_pkg.sv
// Types of the flash programmer command port
package flash_prog_pkg;

  typedef enum logic [2:0] {
    ST_READ    = 3'b000,
    ST_WAIT    = 3'b001,
    ST_ERASE2  = 3'b010,
    ST_STATUS2 = 3'b011,
    ST_LOAD    = 3'b100,
    ST_PROG    = 3'b101,
    ST_ERASE   = 3'b110,
    ST_STATUS  = 3'b111
  } prog_state_t;

endpackage

// >>> design/flash_programmer_cmd_port.sv
// Programmer-mode parallel command port of the on-chip flash
`timescale 1ns/1ps
`include "flash_prog_defines.svh"

module flash_programmer_cmd_port #(
  parameter int unsigned AW           = 17,
  parameter int unsigned PGM_CYCLES   = 32'(`WRITE_CYCLES),
  parameter int unsigned ERASE_CYCLES = 32'(`ERASE_CYCLES)
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        boot_mode_strap2,
  input  wire logic                        boot_mode_strap1,
  input  wire logic                        boot_mode_strap0,
  input  wire logic                        strap_select_a,
  input  wire logic                        strap_select_b,
  input  wire logic                        strap_select_c,
  input  wire logic                        extra_strap_a,
  input  wire logic                        extra_strap_b,
  input  wire logic                        standby_n,
  input  wire logic                        flash_write_permit,
  input  wire logic                        chip_select_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        write_strobe_n,
  input  wire logic [AW-1:0]               addr,
  input  wire logic [7:0]                  data_in,
  output logic      [7:0]                  data_out,
  output logic                             data_oe_n,
  output logic                             programmer_mode,
  output flash_prog_pkg::prog_state_t      op_state
);

  import flash_prog_pkg::*;

  localparam int unsigned PW = `PAGE_WIDTH;

  prog_state_t   state_reg;
  prog_state_t   state_next;
  logic          mode_reg;
  logic          we_low_reg;
  logic [AW-1:0] cap_addr_reg;
  logic [7:0]    cap_data_reg;
  logic          cap_fwe_reg;
  logic [PW-1:0] count_reg;
  logic [AW-1:0] page_base_reg;
  logic [7:0]    status_reg;
  logic [7:0]    err_set;
  logic [7:0]    data_next;
  logic [7:0]    data_out_reg;
  logic [7:0]    rd_data;
  logic          eng_busy;
  logic          eng_done;
  logic          eng_fail;

  // Strap pattern that selects programmer mode
  wire mode_ok = !boot_mode_strap2 && !boot_mode_strap1 && !boot_mode_strap0
               && strap_select_a && !strap_select_b && !strap_select_c
               && extra_strap_a && extra_strap_b && standby_n;

  // Bus cycle decode
  // A write acts at the first edge that sees the strobe back high,
  // so byte and address are taken from the last low sample
  wire read_cycle  = mode_ok && !chip_select_n && !output_enable_n && write_strobe_n;
  wire write_low   = mode_ok && !chip_select_n && output_enable_n && !write_strobe_n;
  wire cmd_write   = we_low_reg && write_strobe_n && !chip_select_n && mode_ok;

  // Command code classification
  wire code_read   = cap_data_reg == `CMD_MEM_READ;
  wire code_pgm    = cap_data_reg == `CMD_AUTO_PGM;
  wire code_erase  = cap_data_reg == `CMD_AUTO_ERASE;
  wire code_status = cap_data_reg == `CMD_STATUS_READ;
  wire pgm_ok      = code_pgm && cap_fwe_reg;
  wire erase_ok    = code_erase && cap_fwe_reg;
  wire first_bad   = !(code_read || pgm_ok || code_erase || code_status);

  // States that take a first command cycle
  wire idle_state  = (state_reg == ST_READ) || (state_reg == ST_WAIT)
                   || (state_reg == ST_STATUS);

  // Command error sources
  wire cmd_err = cmd_write && ((idle_state && first_bad)
               || (state_reg == ST_ERASE2 && !erase_ok)
               || (state_reg == ST_STATUS2 && !code_status));

  // Burst control
  wire load_en      = cmd_write && (state_reg == ST_LOAD);
  wire load_last    = load_en && (count_reg == `PAGE_LAST);
  wire first_data   = load_en && (count_reg == '0);
  wire addr_bad     = (cap_addr_reg[7:0] != `PAGE_ALIGN_LO)
                    && (cap_addr_reg[7:0] != `PAGE_ALIGN_HI);
  wire addr_err_evt = first_data && addr_bad;
  wire start_pgm    = load_last;
  wire start_erase  = cmd_write && (state_reg == ST_ERASE2) && erase_ok;
  wire clear_status = cmd_write && idle_state && (pgm_ok || code_erase);

  // Polling byte after an operation ends
  wire [7:0] poll_byte = status_reg[`ST_ABNORMAL_BIT] ? `POLL_ABNORMAL
                                                      : `POLL_NORMAL;

  // Error bits raised this cycle
  always_comb begin
    err_set                    = 8'h00;
    err_set[`ST_CMD_ERR_BIT]   = cmd_err;
    err_set[`ST_PGM_ERR_BIT]   = eng_done && eng_fail && (state_reg == ST_PROG);
    err_set[`ST_ADDR_ERR_BIT]  = addr_err_evt;
    err_set[`ST_ABNORMAL_BIT]  = cmd_err || addr_err_evt
                               || (eng_done && eng_fail && (state_reg == ST_PROG));
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_READ, ST_WAIT, ST_STATUS: begin
        if (cmd_write) begin
          if (code_read) begin
            state_next = ST_READ;
          end else if (pgm_ok) begin
            state_next = ST_LOAD;
          end else if (code_erase) begin
            state_next = ST_ERASE2;
          end else if (code_status) begin
            state_next = ST_STATUS2;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_ERASE2: begin
        if (cmd_write) begin
          state_next = erase_ok ? ST_ERASE : ST_WAIT;
        end
      end
      ST_STATUS2: begin
        if (cmd_write) begin
          state_next = code_status ? ST_STATUS : ST_WAIT;
        end
      end
      ST_LOAD: begin
        if (load_last) begin
          state_next = ST_PROG;
        end
      end
      ST_PROG, ST_ERASE: begin
        if (eng_done) begin
          state_next = ST_WAIT;
        end
      end
    endcase
  end

  // Byte presented on the data lines
  always_comb begin
    data_next = 8'h00;
    unique case (state_reg)
      ST_READ:             data_next = rd_data;
      ST_WAIT:             data_next = poll_byte;
      ST_STATUS:           data_next = status_reg;
      ST_PROG, ST_ERASE:   data_next = `POLL_BUSY;
      ST_ERASE2, ST_STATUS2, ST_LOAD: data_next = `POLL_BUSY;
    endcase
  end

  // Command state, comes up in memory read mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_READ;
      mode_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_ok;
    end
  end

  // Write cycle capture while the strobe is low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      we_low_reg   <= 1'b0;
      cap_addr_reg <= '0;
      cap_data_reg <= 8'h00;
      cap_fwe_reg  <= 1'b0;
    end else begin
      we_low_reg <= write_low;
      if (write_low) begin
        cap_addr_reg <= addr;
        cap_data_reg <= data_in;
        cap_fwe_reg  <= flash_write_permit;
      end
    end
  end

  // Burst byte counter and page address
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg     <= '0;
      page_base_reg <= '0;
    end else begin
      if (clear_status) begin
        count_reg <= '0;
      end else if (load_en) begin
        count_reg <= count_reg + 1'b1;
      end
      if (first_data) begin
        page_base_reg <= cap_addr_reg;
      end
    end
  end

  // Status return byte, cleared by the program command or the first erase code
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `STATUS_RESET;
    end else if (clear_status) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_reg | err_set;
    end
  end

  // Output data register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out_reg <= 8'h00;
    end else begin
      data_out_reg <= data_next;
    end
  end

  // Array engine keeps running whatever chip select does
  flash_array_engine #(
    .AW           (AW),
    .PW           (PW),
    .PGM_CYCLES   (PGM_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) engine_u (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .load_en     (load_en),
    .load_idx    (count_reg),
    .load_data   (cap_data_reg),
    .start_pgm   (start_pgm),
    .start_erase (start_erase),
    .page_base   (page_base_reg),
    .rd_addr     (addr),
    .rd_data     (rd_data),
    .busy        (eng_busy),
    .done        (eng_done),
    .pgm_fail    (eng_fail)
  );

  // Port drivers
  assign data_out        = data_out_reg;
  assign data_oe_n       = !read_cycle;
  assign programmer_mode = mode_reg;
  assign op_state        = state_reg;

  // Checks
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  bus_float_a: assert property (
    (chip_select_n || write_strobe_n == output_enable_n) |-> data_oe_n)
    else $error("data bus driven outside a read cycle");

  read_hold_a: assert property (
    (state_reg == ST_READ && !cmd_write) |=> state_reg == ST_READ)
    else $error("memory read mode left without a command");

  // Array bytes stay unknown until the first erase, hence the four-state compare
  read_data_a: assert property (
    (state_reg == ST_READ) ##1 (state_reg == ST_READ) |-> data_out_reg === $past(rd_data))
    else $error("read byte does not follow the array");

  cmd_decode_a: assert property (
    (state_reg == ST_READ && cmd_write && code_erase) |=> state_reg == ST_ERASE2)
    else $error("command not decoded in memory read mode");

  burst_end_a: assert property (
    (state_reg == ST_LOAD && cmd_write && count_reg == `PAGE_LAST)
    |=> state_reg == ST_PROG && eng_busy)
    else $error("128th data write did not start programming");

  addr_err_a: assert property (
    (state_reg == ST_LOAD && first_data && addr_bad)
    |=> status_reg[`ST_ADDR_ERR_BIT] && status_reg[`ST_ABNORMAL_BIT] && state_reg == ST_LOAD)
    else $error("bad page address not flagged");

  erase_start_a: assert property (
    start_erase |=> state_reg == ST_ERASE ##1 eng_busy)
    else $error("second erase code did not start erase");

  // Program and erase both hand back to command wait, never to read mode
  op_done_a: assert property (
    (eng_done && (state_reg == ST_PROG || state_reg == ST_ERASE)) |=> state_reg == ST_WAIT)
    else $error("finished operation did not reach command wait");

  poll_busy_a: assert property (
    (state_reg == ST_PROG || state_reg == ST_ERASE) |=> data_out_reg == `POLL_BUSY)
    else $error("polling byte wrong during operation");

  poll_end_a: assert property (
    (state_reg == ST_WAIT && !status_reg[`ST_ABNORMAL_BIT]) |=> data_out_reg == `POLL_NORMAL)
    else $error("normal end not shown on bit 6");

  status_out_a: assert property (
    (state_reg == ST_STATUS) |=> data_out_reg == $past(status_reg))
    else $error("status byte not presented");

  cmd_error_a: assert property (
    (idle_state && cmd_write && first_bad)
    |=> state_reg == ST_WAIT && status_reg[`ST_CMD_ERR_BIT])
    else $error("unknown command not flagged");

  fwe_gate_a: assert property (
    (idle_state && cmd_write && code_pgm && !cap_fwe_reg) |=> state_reg != ST_LOAD)
    else $error("program entered without write permit");

endmodule

// >>> verification/prog_bus_model.sv
// External programmer model driving the parallel command bus
`timescale 1ns/1ps
module prog_bus_model #(
  parameter int unsigned AW = 17
) (
  input  wire logic          sys_clk,
  output logic               boot_mode_strap2,
  output logic               boot_mode_strap1,
  output logic               boot_mode_strap0,
  output logic               strap_select_a,
  output logic               strap_select_b,
  output logic               strap_select_c,
  output logic               extra_strap_a,
  output logic               extra_strap_b,
  output logic               standby_n,
  output logic               flash_write_permit,
  output logic               chip_select_n,
  output logic               output_enable_n,
  output logic               write_strobe_n,
  output logic [AW-1:0]      addr,
  output logic [7:0]         data_in,
  input  wire logic [7:0]    data_out,
  input  wire logic          data_oe_n
);
  // Programmer-mode strap pattern, bus idle
  initial begin
    {boot_mode_strap2, boot_mode_strap1, boot_mode_strap0} = 3'b000;
    {strap_select_a, strap_select_b, strap_select_c} = 3'b100;
    {extra_strap_a, extra_strap_b, standby_n} = 3'b111;
    flash_write_permit = 1'b0;
    {chip_select_n, output_enable_n, write_strobe_n} = 3'b111;
    addr = '0;
    data_in = 8'h5a;
  end

  // Spoil one strap or restore the pattern
  task automatic set_straps(input logic ok);
    @(posedge sys_clk);
    strap_select_b <= ~ok;
  endtask

  // One cycle of given strobe levels, released lines toggling
  task automatic bus_set(input logic cs_n, input logic oe_n, input logic we_n);
    @(posedge sys_clk);
    chip_select_n <= cs_n;
    output_enable_n <= oe_n;
    write_strobe_n <= we_n;
    addr <= ~addr;
    data_in <= ~data_in;
  endtask

  // Command or data write; address driven only where asked
  task automatic cmd_write(input logic [7:0] d, input logic [AW-1:0] a,
                           input logic permit, input logic give_addr);
    @(posedge sys_clk);
    {chip_select_n, output_enable_n, write_strobe_n} <= 3'b010;
    flash_write_permit <= permit;
    data_in <= d;
    addr <= give_addr ? a : ~addr;
    @(posedge sys_clk);
    write_strobe_n <= 1'b1;
    @(posedge sys_clk);
    data_in <= ~d;
    flash_write_permit <= 1'b0;
  endtask

  // Read cycle; data taken two edges after the address is seen
  task automatic bus_read(input logic [AW-1:0] a, output logic [7:0] d, output logic oe_n);
    @(posedge sys_clk);
    {chip_select_n, output_enable_n, write_strobe_n} <= 3'b001;
    addr <= a;
    repeat (3) @(posedge sys_clk);
    #1;
    d = data_oe_n ? ~data_out : data_out;
    oe_n = data_oe_n;
  endtask
endmodule

// >>> verification/tb_flash_programmer_cmd_port.sv
// Self-checking bench for the programmer command port
`timescale 1ns/1ps
module tb_flash_programmer_cmd_port;
  import flash_prog_pkg::*;
  localparam int unsigned AW = 10;
  localparam int unsigned PGM_CYC = 300;
  localparam int unsigned ERASE_CYC = 2000;

  logic        sys_clk;
  logic        rst_b;
  wire logic   ms2, ms1, ms0, ssa, ssb, ssc, esa, esb, standby_n_n, permit;
  wire logic   cs_n, oe_n, we_n, dout_oe_n, programmer_mode;
  wire logic [AW-1:0] addr;
  wire logic [7:0]    data_in, data_out;
  prog_state_t        op_state;
  int          error_cnt;
  int          total_checks;
  logic [7:0]  mem [0:(1<<AW)-1];
  logic [7:0]  exp_st;
  logic [7:0]  rd;
  logic        rd_oe_n;

  flash_programmer_cmd_port #(.AW(AW), .PGM_CYCLES(PGM_CYC), .ERASE_CYCLES(ERASE_CYC)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .boot_mode_strap2(ms2), .boot_mode_strap1(ms1),
    .boot_mode_strap0(ms0), .strap_select_a(ssa), .strap_select_b(ssb), .strap_select_c(ssc),
    .extra_strap_a(esa), .extra_strap_b(esb), .standby_n(standby_n_n), .flash_write_permit(permit),
    .chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(dout_oe_n),
    .programmer_mode(programmer_mode), .op_state(op_state));

  prog_bus_model #(.AW(AW)) host (
    .sys_clk(sys_clk), .boot_mode_strap2(ms2), .boot_mode_strap1(ms1),
    .boot_mode_strap0(ms0), .strap_select_a(ssa), .strap_select_b(ssb), .strap_select_c(ssc),
    .extra_strap_a(esa), .extra_strap_b(esb), .standby_n(standby_n_n), .flash_write_permit(permit),
    .chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(dout_oe_n));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Compare one value, count and report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Settled state after the executing edge of a write
  task automatic state_is(input prog_state_t s);
    #1;
    check("op_state", op_state, s);
  endtask

  // Poll status until the engine stops reporting busy
  task automatic poll(input logic [7:0] exp);
    for (int k = 0; k < 40; k++) begin
      host.bus_read('0, rd, rd_oe_n);
      if (rd !== 8'h00) break;
    end
    check("poll", rd, exp);
    check("poll_oe", rd_oe_n, 1'b0);
  endtask

  // Two status commands and a read of the return byte
  task automatic status_is(input logic [7:0] exp);
    host.cmd_write(8'h71, '0, 1'b0, 1'b0);
    host.cmd_write(8'h71, '0, 1'b0, 1'b0);
    host.bus_read('0, rd, rd_oe_n);
    check("status", rd, exp);
  endtask

  // Auto-program burst with model of expected status and contents
  task automatic program_page(input logic [AW-1:0] pa, input logic rnd);
    logic [7:0]    b;
    logic [7:0]    pg[$];
    logic [AW-1:0] base;
    base = {pa[AW-1:7], 7'h00};
    exp_st = 8'h00;
    if (pa[7:0] != 8'h00 && pa[7:0] != 8'h80) exp_st = 8'h81;
    host.cmd_write(8'h40, '0, 1'b1, 1'b0);
    for (int i = 0; i < 128; i++) begin
      b = rnd ? 8'($urandom_range(0, 255)) : 8'hff;
      if ((b & ~mem[base + AW'(i)]) != 8'h00) exp_st = exp_st | 8'ha0;
      pg.push_back(b);
      host.cmd_write(b, pa, 1'b0, i == 0);
    end
    state_is(ST_PROG);
    // Programming only clears bits, so a failed byte keeps its zeros
    for (int i = 0; i < 128; i++) mem[base + AW'(i)] = mem[base + AW'(i)] & pg[i];
    repeat (PGM_CYC + 50) host.bus_set(1'b1, 1'b1, 1'b1);
    poll(exp_st[7] ? 8'h80 : 8'hc0);
    state_is(ST_WAIT);
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    total_checks = 0;
    exp_st = 8'h00;
    void'($urandom(32'h1f7a));
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("reset_state", op_state, ST_READ);
    check("mode_on", programmer_mode, 1'b1);
    host.bus_set(1'b1, 1'b1, 1'b1);
    #1;
    check("deselect_oe", dout_oe_n, 1'b1);
    host.bus_set(1'b0, 1'b1, 1'b1);
    #1;
    check("disable_oe", dout_oe_n, 1'b1);
    host.set_straps(1'b0);
    host.bus_read('0, rd, rd_oe_n);
    check("mode_off", programmer_mode, 1'b0);
    check("mode_off_oe", rd_oe_n, 1'b1);
    host.set_straps(1'b1);
    host.bus_set(1'b1, 1'b1, 1'b1);
    // Whole-array erase, then array reads from wait need a read command
    host.cmd_write(8'h20, '0, 1'b1, 1'b0);
    host.cmd_write(8'h20, '0, 1'b1, 1'b0);
    state_is(ST_ERASE);
    for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hff;
    repeat (ERASE_CYC + 50) host.bus_set(1'b1, 1'b1, 1'b1);
    poll(8'hc0);
    state_is(ST_WAIT);
    host.cmd_write(8'h00, 10'h155, 1'b0, 1'b1);
    state_is(ST_READ);
    for (int i = 0; i < 8; i++) begin
      host.bus_read(AW'($urandom_range(0, (1 << AW) - 1)), rd, rd_oe_n);
      check("erased", rd, 8'hff);
    end
    // Random page, read back through a fresh read command
    program_page(10'h080, 1'b1);
    host.cmd_write(8'h00, '0, 1'b0, 1'b0);
    for (int i = 0; i < 129; i++) begin
      host.bus_read(AW'(10'h080 + i), rd, rd_oe_n);
      check("readback", rd, mem[10'h080 + i]);
    end
    status_is(8'h00);
    // Misaligned page address and reprogramming ones over zeros
    program_page(10'h110, 1'b0);
    status_is(exp_st);
    program_page(10'h080, 1'b0);
    status_is(exp_st);
    // Command errors: unknown code, missing permit, broken second cycle
    host.cmd_write(8'h55, '0, 1'b1, 1'b0);
    state_is(ST_WAIT);
    exp_st = exp_st | 8'hc0;
    poll(8'h80);
    host.cmd_write(8'h40, '0, 1'b0, 1'b0);
    state_is(ST_WAIT);
    host.cmd_write(8'h71, '0, 1'b0, 1'b0);
    host.cmd_write(8'h00, '0, 1'b0, 1'b0);
    state_is(ST_WAIT);
    status_is(exp_st);
    // Second erase code without write permit is refused
    host.cmd_write(8'h20, '0, 1'b1, 1'b0);
    host.cmd_write(8'h20, '0, 1'b0, 1'b0);
    state_is(ST_WAIT);
    status_is(8'hc0);
    tally_and_finish();
  end
endmodule
